//--- eim_pkg.sv
`default_nettype none
package eim_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned DEBOUNCE_US    = 10000;
  localparam int unsigned HOLD_ENTER_S   = 3;
  localparam int unsigned HOLD_PEAK_S    = 6;
  localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned HOLD_ENTER_CYC = HOLD_ENTER_S * CLK_MHZ * 1000000;
  localparam int unsigned HOLD_PEAK_CYC  = HOLD_PEAK_S * CLK_MHZ * 1000000;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SP1    = 8'h04;
  localparam logic [7:0] OFS_SP2    = 8'h08;
  localparam logic [7:0] OFS_BAND1  = 8'h0C;
  localparam logic [7:0] OFS_INT1   = 8'h10;
  localparam logic [7:0] OFS_DER1   = 8'h14;
  localparam logic [7:0] OFS_BAND2  = 8'h18;
  localparam logic [7:0] OFS_INT2   = 8'h1C;
  localparam logic [7:0] OFS_DER2   = 8'h20;
  localparam logic [7:0] OFS_MANUAL = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_ACTSP  = 8'h2C;
  localparam logic [7:0] OFS_ACTPID = 8'h30;
  localparam logic [7:0] OFS_PEAK   = 8'h34;
  localparam logic [7:0] OFS_HEATER = 8'h38;
  localparam logic [7:0] OFS_DRIVE  = 8'h3C;
  localparam logic [7:0] OFS_FILE   = 8'h40;

  localparam int unsigned CTRL_FN_LSB   = 0;
  localparam int unsigned CTRL_COOL_BIT = 4;
  localparam int unsigned CTRL_CT_BIT   = 5;
  localparam int unsigned CTRL_LAT1_BIT = 6;
  localparam int unsigned CTRL_LAT2_BIT = 7;

  localparam logic [7:0]  RST_CTRL   = 8'h00;
  localparam logic [15:0] RST_SP     = 16'h0000;
  localparam logic [15:0] RST_BAND   = 16'h00B4;
  localparam logic [15:0] RST_INT    = 16'h0064;
  localparam logic [15:0] RST_DER    = 16'h00FA;
  localparam logic [15:0] RST_PCT    = 16'h0000;
  localparam logic [15:0] PEAK_HI_RST = 16'h0000;
  localparam logic [15:0] PEAK_LO_RST = 16'hFFFF;

  typedef enum logic [3:0] {
    EVFN_NONE       = 4'h0,
    EVFN_SP2        = 4'h1,
    EVFN_TUNE2      = 4'h2,
    EVFN_BOTH2      = 4'h3,
    EVFN_CLR_A1     = 4'h4,
    EVFN_CLR_A2     = 4'h5,
    EVFN_CLR_A12    = 4'h6,
    EVFN_KILL_O1    = 4'h7,
    EVFN_KILL_O2    = 4'h8,
    EVFN_KILL_O12   = 4'h9,
    EVFN_LOCK       = 4'hA
  } eim_evfn_t;

  typedef enum logic [1:0] {
    MENU_NONE = 2'b00,
    MENU_HAND = 2'b01,
    MENU_DISP = 2'b10,
    MENU_FILE = 2'b11
  } eim_menu_t;
endpackage : eim_pkg
`default_nettype wire

//--- eim_top.sv
// Summary of operation
// - Function none ignores the event, using primary set point and tuning terms.
// - Set point function: active event selects the secondary set point.
// - Tuning function: active event selects secondary band, integral, derivative.
// - Combined function: active event swaps set point and all tuning terms.
// - Tuning results go to secondary storage while the secondary set is selected.
// - Alarm-1 clear function clears alarm 1; persisting condition retriggers on release.
// - Alarm-2 clear function clears alarm 2; persisting condition retriggers on release.
// - Dual clear function clears both alarms; persisting ones retrigger on release.
// - Output-1 kill function forces output 1 drive to zero.
// - Output-2 kill function forces output 2 drive to zero.
// - Dual kill function zeroes both output drives one cycle after the debounced event goes active.
// - Killed outputs return to computed drive once the event releases.
// - Lock function blocks every bus parameter write while the event is active; reload and tuning results still write.
// - Function key held 3 s on hand menu enters manual mode, flashing display.
// - Manual mode drives output 1 open loop from the heating percentage.
// - Cooling percentage goes to output 2 only if output 2 is cooling.
// - Manual mode is refused while the active proportional band is zero.
// - Exit keys leave manual mode, back to the previous failure or normal mode.
// - Peak high and low values tracked; 6 s key hold clears and restarts them.
// - Heater current reading updates only while heater is powered, else holds.
// - Default selector accepts 0 or 1; 3 s hold reloads all other parameters.
// - Display mode changes no control operation and lasts until exit keys.
`timescale 1ns/1ns
`default_nettype none
module eim_top #(
  parameter int unsigned P_DEBOUNCE_CYC = eim_pkg::DEBOUNCE_CYC,
  parameter int unsigned P_HOLD_ENTER   = eim_pkg::HOLD_ENTER_CYC,
  parameter int unsigned P_HOLD_PEAK    = eim_pkg::HOLD_PEAK_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_event_in,
  input  wire logic        i_key_func,
  input  wire logic        i_key_exit,
  input  wire eim_pkg::eim_menu_t i_menu,
  input  wire logic [15:0] i_pid_output_one,
  input  wire logic [15:0] i_pid_output_two,
  input  wire logic        i_alarm1_cond,
  input  wire logic        i_alarm2_cond,
  input  wire logic        i_fail_mode,
  input  wire logic        i_tune_done,
  input  wire logic [15:0] i_tune_band,
  input  wire logic [15:0] i_tune_int,
  input  wire logic [15:0] i_tune_der,
  input  wire logic        i_pv_valid,
  input  wire logic [15:0] i_pv,
  input  wire logic        i_heater_on,
  input  wire logic        i_ct_valid,
  input  wire logic [15:0] i_ct_sample,
  output logic [15:0]      o_active_sp,
  output logic [15:0]      o_active_band,
  output logic [15:0]      o_active_int,
  output logic [15:0]      o_active_der,
  output logic [15:0]      o_output_one_drive,
  output logic [15:0]      o_output_two_drive,
  output logic             o_alarm1,
  output logic             o_alarm2,
  output logic             o_manual,
  output logic             o_flash,
  output logic             o_disp_mode,
  output logic             o_reload,
  output logic             o_reload_file
);
  import eim_pkg::*;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // Reset release
  logic rst_meta_ff, rst_n_ff;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // Event synchroniser and debounce
  logic        ev_meta_ff, ev_sync_ff, ev_ff;
  logic [31:0] deb_cnt_ff;
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ev_meta_ff <= 1'b0;
      ev_sync_ff <= 1'b0;
      ev_ff      <= 1'b0;
      deb_cnt_ff <= 32'h00000000;
    end else begin
      ev_meta_ff <= i_event_in;
      ev_sync_ff <= ev_meta_ff;
      if (ev_sync_ff == ev_ff) begin
        deb_cnt_ff <= 32'h00000000;
      end else if (deb_cnt_ff >= P_DEBOUNCE_CYC - 1) begin
        ev_ff      <= ev_sync_ff;
        deb_cnt_ff <= 32'h00000000;
      end else begin
        deb_cnt_ff <= deb_cnt_ff + 32'h00000001;
      end
    end
  end

  // Parameter registers
  logic [7:0]  ctrl_ff;
  logic [15:0] sp1_ff, sp2_ff, band1_ff, int1_ff, der1_ff, band2_ff, int2_ff, der2_ff;
  logic [15:0] heat_pct_ff, cool_pct_ff;
  logic        file_sel_ff;
  eim_evfn_t   fn;
  assign fn = eim_evfn_t'(ctrl_ff[CTRL_FN_LSB +: 4]);

  logic ev_sp2, ev_tune2, clr1, clr2, kill1, kill2, lock;
  assign ev_sp2   = ev_ff && (fn == EVFN_SP2 || fn == EVFN_BOTH2);
  assign ev_tune2 = ev_ff && (fn == EVFN_TUNE2 || fn == EVFN_BOTH2);
  assign clr1     = ev_ff && (fn == EVFN_CLR_A1 || fn == EVFN_CLR_A12);
  assign clr2     = ev_ff && (fn == EVFN_CLR_A2 || fn == EVFN_CLR_A12);
  assign kill1    = ev_ff && (fn == EVFN_KILL_O1 || fn == EVFN_KILL_O12);
  assign kill2    = ev_ff && (fn == EVFN_KILL_O2 || fn == EVFN_KILL_O12);
  assign lock     = ev_ff && (fn == EVFN_LOCK);

  // Bus slave: one wait cycle, answer on the second
  logic ack_ff;
  logic req;
  logic wr_go;
  assign req               = i_avs_read || i_avs_write;
  assign o_avs_waitrequest = req && !ack_ff;
  assign wr_go             = i_avs_write && ack_ff && !lock;
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req && !ack_ff;
    end
  end

  // Key hold timing, one event per press
  logic [31:0] hold_cnt_ff;
  logic        hold_enter, hold_peak, func_prev_ff, func_press;
  assign hold_enter = i_key_func && (hold_cnt_ff == P_HOLD_ENTER - 1);
  assign hold_peak  = i_key_func && (hold_cnt_ff == P_HOLD_PEAK - 1);
  assign func_press = i_key_func && !func_prev_ff;
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      hold_cnt_ff  <= 32'h00000000;
      func_prev_ff <= 1'b0;
    end else begin
      func_prev_ff <= i_key_func;
      if (!i_key_func) begin
        hold_cnt_ff <= 32'h00000000;
      end else if (hold_cnt_ff != 32'hFFFFFFFF) begin
        hold_cnt_ff <= hold_cnt_ff + 32'h00000001;
      end
    end
  end

  logic do_reload;
  assign do_reload = hold_enter && (i_menu == MENU_FILE);

  // Parameter store; reload and tuning share it with software
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ctrl_ff <= RST_CTRL;
      sp1_ff <= RST_SP;
      sp2_ff <= RST_SP;
      band1_ff <= RST_BAND;
      int1_ff <= RST_INT;
      der1_ff <= RST_DER;
      band2_ff <= RST_BAND;
      int2_ff <= RST_INT;
      der2_ff <= RST_DER;
      heat_pct_ff <= RST_PCT;
      cool_pct_ff <= RST_PCT;
      file_sel_ff <= 1'b0;
    end else if (do_reload) begin
      ctrl_ff <= RST_CTRL;
      sp1_ff <= RST_SP;
      sp2_ff <= RST_SP;
      band1_ff <= RST_BAND;
      int1_ff <= RST_INT;
      der1_ff <= RST_DER;
      band2_ff <= RST_BAND;
      int2_ff <= RST_INT;
      der2_ff <= RST_DER;
      heat_pct_ff <= RST_PCT;
      cool_pct_ff <= RST_PCT;
    end else if (i_tune_done) begin
      if (ev_tune2) begin
        band2_ff <= i_tune_band;
        int2_ff  <= i_tune_int;
        der2_ff  <= i_tune_der;
      end else begin
        band1_ff <= i_tune_band;
        int1_ff  <= i_tune_int;
        der1_ff  <= i_tune_der;
      end
    end else if (wr_go) begin
      case (i_avs_address)
        OFS_CTRL: if (i_avs_byteenable[0]) ctrl_ff <= i_avs_writedata[7:0];
        OFS_SP1:   sp1_ff   <= merge16(sp1_ff, i_avs_writedata[15:0], i_avs_byteenable[1:0]);
        OFS_SP2:   sp2_ff   <= merge16(sp2_ff, i_avs_writedata[15:0], i_avs_byteenable[1:0]);
        OFS_BAND1: band1_ff <= merge16(band1_ff, i_avs_writedata[15:0], i_avs_byteenable[1:0]);
        OFS_INT1:  int1_ff  <= merge16(int1_ff, i_avs_writedata[15:0], i_avs_byteenable[1:0]);
        OFS_DER1:  der1_ff  <= merge16(der1_ff, i_avs_writedata[15:0], i_avs_byteenable[1:0]);
        OFS_BAND2: band2_ff <= merge16(band2_ff, i_avs_writedata[15:0], i_avs_byteenable[1:0]);
        OFS_INT2:  int2_ff  <= merge16(int2_ff, i_avs_writedata[15:0], i_avs_byteenable[1:0]);
        OFS_DER2:  der2_ff  <= merge16(der2_ff, i_avs_writedata[15:0], i_avs_byteenable[1:0]);
        OFS_MANUAL: begin
          heat_pct_ff <= merge16(heat_pct_ff, i_avs_writedata[15:0], i_avs_byteenable[1:0]);
          cool_pct_ff <= merge16(cool_pct_ff, i_avs_writedata[31:16], i_avs_byteenable[3:2]);
        end
        // Low-byte values above one are refused, old selection kept
        OFS_FILE: if (i_avs_byteenable[0] && i_avs_writedata[7:1] == 7'h00) begin
          file_sel_ff <= i_avs_writedata[0];
        end
        default: ;
      endcase
    end
  end

  // Active set point and tuning terms
  logic [15:0] nxt_sp, nxt_band, nxt_int, nxt_der;
  always_comb begin
    nxt_sp   = ev_sp2 ? sp2_ff : sp1_ff;
    nxt_band = ev_tune2 ? band2_ff : band1_ff;
    nxt_int  = ev_tune2 ? int2_ff : int1_ff;
    nxt_der  = ev_tune2 ? der2_ff : der1_ff;
  end
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      o_active_sp   <= RST_SP;
      o_active_band <= RST_BAND;
      o_active_int  <= RST_INT;
      o_active_der  <= RST_DER;
    end else begin
      o_active_sp   <= nxt_sp;
      o_active_band <= nxt_band;
      o_active_int  <= nxt_int;
      o_active_der  <= nxt_der;
    end
  end

  // Alarms: clear holds them off, condition retriggers after release
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      o_alarm1 <= 1'b0;
      o_alarm2 <= 1'b0;
    end else begin
      o_alarm1 <= !clr1 && (i_alarm1_cond || (o_alarm1 && ctrl_ff[CTRL_LAT1_BIT]));
      o_alarm2 <= !clr2 && (i_alarm2_cond || (o_alarm2 && ctrl_ff[CTRL_LAT2_BIT]));
    end
  end

  // Manual and display modes
  logic prev_fail_ff;
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      o_manual     <= 1'b0;
      o_disp_mode  <= 1'b0;
      prev_fail_ff <= 1'b0;
    end else begin
      if (i_key_exit) begin
        o_manual <= 1'b0;
      end else if (hold_enter && i_menu == MENU_HAND && nxt_band != 16'h0000) begin
        o_manual     <= 1'b1;
        prev_fail_ff <= i_fail_mode;
      end
      // Display mode only gates what is shown, never control
      if (i_key_exit) begin
        o_disp_mode <= 1'b0;
      end else if (func_press && i_menu == MENU_DISP) begin
        o_disp_mode <= 1'b1;
      end
    end
  end
  assign o_flash = o_manual;

  // Output drive; kill outranks manual
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      o_output_one_drive <= 16'h0000;
      o_output_two_drive <= 16'h0000;
    end else begin
      if (kill1) begin
        o_output_one_drive <= 16'h0000;
      end else if (o_manual) begin
        o_output_one_drive <= heat_pct_ff;
      end else begin
        o_output_one_drive <= i_pid_output_one;
      end
      if (kill2) begin
        o_output_two_drive <= 16'h0000;
      end else if (o_manual && ctrl_ff[CTRL_COOL_BIT]) begin
        o_output_two_drive <= cool_pct_ff;
      end else begin
        o_output_two_drive <= i_pid_output_two;
      end
    end
  end

  // Peaks, heater current, reload strobe
  logic [15:0] peak_hi_ff, peak_lo_ff, heater_ff;
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      peak_hi_ff    <= PEAK_HI_RST;
      peak_lo_ff    <= PEAK_LO_RST;
      heater_ff     <= 16'h0000;
      o_reload      <= 1'b0;
      o_reload_file <= 1'b0;
    end else begin
      if (hold_peak && i_menu == MENU_DISP) begin
        peak_hi_ff <= PEAK_HI_RST;
        peak_lo_ff <= PEAK_LO_RST;
      end else if (i_pv_valid) begin
        if (i_pv > peak_hi_ff) peak_hi_ff <= i_pv;
        if (i_pv < peak_lo_ff) peak_lo_ff <= i_pv;
      end
      if (ctrl_ff[CTRL_CT_BIT] && i_heater_on && i_ct_valid) begin
        heater_ff <= i_ct_sample;
      end
      o_reload <= do_reload;
      if (do_reload) o_reload_file <= file_sel_ff;
    end
  end

  // Read data, registered on the wait cycle
  logic [31:0] nxt_rdata;
  always_comb begin
    case (i_avs_address)
      OFS_CTRL:   nxt_rdata = {24'h000000, ctrl_ff};
      OFS_SP1:    nxt_rdata = {16'h0000, sp1_ff};
      OFS_SP2:    nxt_rdata = {16'h0000, sp2_ff};
      OFS_BAND1:  nxt_rdata = {16'h0000, band1_ff};
      OFS_INT1:   nxt_rdata = {16'h0000, int1_ff};
      OFS_DER1:   nxt_rdata = {16'h0000, der1_ff};
      OFS_BAND2:  nxt_rdata = {16'h0000, band2_ff};
      OFS_INT2:   nxt_rdata = {16'h0000, int2_ff};
      OFS_DER2:   nxt_rdata = {16'h0000, der2_ff};
      OFS_MANUAL: nxt_rdata = {cool_pct_ff, heat_pct_ff};
      OFS_STATUS: nxt_rdata = {22'h000000, prev_fail_ff, o_disp_mode, o_manual, lock,
                               o_alarm2, o_alarm1, ev_tune2, ev_sp2, i_fail_mode, ev_ff};
      OFS_ACTSP:  nxt_rdata = {16'h0000, o_active_sp};
      OFS_ACTPID: nxt_rdata = {o_active_int, o_active_band};
      OFS_PEAK:   nxt_rdata = {peak_lo_ff, peak_hi_ff};
      OFS_HEATER: nxt_rdata = {16'h0000, heater_ff};
      OFS_DRIVE:  nxt_rdata = {o_output_two_drive, o_output_one_drive};
      OFS_FILE:   nxt_rdata = {31'h00000000, file_sel_ff};
      default:    nxt_rdata = 32'h00000000;
    endcase
  end
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      o_avs_readdata <= 32'h00000000;
    end else if (i_avs_read && !ack_ff) begin
      o_avs_readdata <= nxt_rdata;
    end
  end

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n_ff);

  a_nofn_primary: assert property (fn == EVFN_NONE |=> o_active_sp == $past(sp1_ff)
    && o_active_band == $past(band1_ff)) else $error("primary set not used");
  a_sp_swap: assert property (ev_sp2 |=> o_active_sp == $past(sp2_ff))
    else $error("secondary set point not applied");
  a_tune_swap: assert property (ev_tune2 |=> o_active_band == $past(band2_ff)
    && o_active_der == $past(der2_ff)) else $error("secondary tuning not applied");
  a_tune_store: assert property (i_tune_done && ev_tune2 && !do_reload
    |=> band2_ff == $past(i_tune_band)) else $error("tuning stored in wrong set");
  a_alarm_clear: assert property (clr1 |=> !o_alarm1)
    else $error("alarm 1 not cleared");
  a_alarm_retrig: assert property ($fell(clr2) && i_alarm2_cond |=> o_alarm2)
    else $error("alarm 2 not retriggered");
  a_kill_zero: assert property (kill1 |=> o_output_one_drive == 16'h0000)
    else $error("output 1 not killed");
  a_kill_restore: assert property (!kill2 && !o_manual
    |=> o_output_two_drive == $past(i_pid_output_two)) else $error("output 2 not restored");
  a_lock_hold: assert property (lock && i_avs_write && !do_reload && !i_tune_done
    |=> $stable(sp1_ff) && $stable(band1_ff)) else $error("write passed lock");
  a_manual_refuse: assert property ($rose(o_manual) |-> $past(nxt_band) != 16'h0000)
    else $error("manual entered with zero band");
  a_manual_exit: assert property (i_key_exit |=> !o_manual && !o_disp_mode)
    else $error("exit keys ignored");
  a_wait_one: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("waitrequest held too long");

  c_manual_entry: cover property ($rose(o_manual));
  c_kill_both: cover property (kill1 && kill2 ##1 !kill1);
  c_tune_second: cover property (i_tune_done && ev_tune2);
endmodule : eim_top
`default_nettype wire

//--- eim_event_src.sv
`timescale 1ns/1ns
`default_nettype none
module eim_event_src (
  input  wire logic i_clk,
  input  wire logic i_press,
  output var logic  o_event
);
  logic last_ff = 1'b0;
  int   bnc = 0;
  // Contact chatters for a few cycles on every change, so one closure
  // must still give one clean activation inside the block
  always @(posedge i_clk) begin
    last_ff <= i_press;
    if (last_ff != i_press) begin
      bnc <= 3;
    end else if (bnc > 0) begin
      bnc <= bnc - 1;
    end
    o_event <= (bnc > 0) ? ~o_event : i_press;
  end
endmodule : eim_event_src
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import eim_pkg::*;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [7:0]  i_avs_address = 8'h00;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, q;
  logic [3:0]  i_avs_byteenable = 4'hF;
  logic        o_avs_waitrequest, i_event_in, i_key_func = 1'b0, i_key_exit = 1'b0;
  eim_menu_t   i_menu = MENU_NONE;
  logic [15:0] i_pid_output_one = 16'h1111, i_pid_output_two = 16'h2222, i_pv = 16'h0;
  logic [15:0] i_tune_band = 16'h0, i_tune_int = 16'h0, i_tune_der = 16'h0;
  logic [15:0] i_ct_sample = 16'h0;
  logic        i_alarm1_cond = 1'b1, i_alarm2_cond = 1'b1, i_fail_mode = 1'b0;
  logic        i_tune_done = 1'b0, i_pv_valid = 1'b0, i_heater_on = 1'b0;
  logic        i_ct_valid = 1'b0, press = 1'b0;
  logic [15:0] o_active_sp, o_active_band, o_active_int, o_active_der;
  logic [15:0] o_output_one_drive, o_output_two_drive;
  logic        o_alarm1, o_alarm2, o_manual, o_flash, o_disp_mode, o_reload, o_reload_file;
  int          fails = 0, checks_done = 0, reloads = 0;
  // Short counts keep the run small; expectations use the same values
  eim_top #(.P_DEBOUNCE_CYC(4), .P_HOLD_ENTER(20), .P_HOLD_PEAK(40)) eim_top_i (.*);
  eim_event_src eim_event_src_i (.i_clk(i_clk), .i_press(press), .o_event(i_event_in));
  always #5 i_clk = ~i_clk;
  // Reload must be a single pulse per long press
  always @(posedge i_clk) begin
    if (o_reload === 1'b1) reloads++;
  end
  task automatic complete_run;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= w;
    i_avs_read <= !w;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    if (n >= 50) begin
      fails++;
      complete_run();
    end
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rdc
  task automatic ev(input logic v);
    @(posedge i_clk);
    press <= v;
    repeat (20) @(posedge i_clk);
    #1;
  endtask : ev
  task automatic hold(input eim_menu_t m, input int n, input logic x);
    @(posedge i_clk);
    i_menu <= m;
    i_key_func <= !x;
    i_key_exit <= x;
    repeat (n) @(posedge i_clk);
    i_key_func <= 1'b0;
    i_key_exit <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
  endtask : hold
  task automatic smp(input logic c, input logic [15:0] v);
    @(posedge i_clk);
    i_pv <= v;
    i_ct_sample <= v;
    i_pv_valid <= !c;
    i_ct_valid <= c;
    @(posedge i_clk);
    i_pv_valid <= 1'b0;
    i_ct_valid <= 1'b0;
  endtask : smp
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    chk({o_active_der, o_active_int, o_active_band}, {RST_DER, RST_INT, RST_BAND});
    rdc(OFS_CTRL, 32'h0);
    rdc(8'h44, 32'h0);
    bus(1'b1, OFS_SP1, 32'h0123);
    bus(1'b1, OFS_SP2, 32'h0456);
    bus(1'b1, OFS_BAND2, 32'h0011);
    bus(1'b1, OFS_INT2, 32'h0022);
    bus(1'b1, OFS_DER2, 32'h0033);
    for (int f = 0; f < 11; f++) begin
      bus(1'b1, OFS_CTRL, 32'(f));
      ev(1'b1);
      if (f < 4) begin
        chk(o_active_sp, (f == 1 || f == 3) ? 32'h0456 : 32'h0123);
        chk({o_active_der, o_active_int, o_active_band},
            (f >= 2) ? 48'h003300220011 : {RST_DER, RST_INT, RST_BAND});
      end else if (f < 7) begin
        chk({o_alarm2, o_alarm1}, {f == 4, f == 5});
      end else if (f < 10) begin
        chk({o_output_two_drive, o_output_one_drive},
            {(f == 7) ? 16'h2222 : 16'h0, (f == 8) ? 16'h1111 : 16'h0});
      end else begin
        bus(1'b1, OFS_SP1, 32'h0999);
      end
      if (f == 3) begin
        @(posedge i_clk);
        i_tune_band <= 16'h0077;
        i_tune_done <= 1'b1;
        @(posedge i_clk);
        i_tune_done <= 1'b0;
        rdc(OFS_BAND2, 32'h0077);
        rdc(OFS_BAND1, {16'h0, RST_BAND});
      end
      ev(1'b0);
      chk({o_alarm2, o_alarm1, o_output_two_drive, o_output_one_drive}, 34'h322221111);
    end
    // Latched alarm holds after its condition goes, until the clear event
    bus(1'b1, OFS_CTRL, 32'h44);
    i_alarm1_cond <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    chk(o_alarm1, 1'b1);
    ev(1'b1);
    ev(1'b0);
    chk(o_alarm1, 1'b0);
    rdc(OFS_SP1, 32'h0123);
    bus(1'b1, OFS_CTRL, 32'h10);
    bus(1'b1, OFS_MANUAL, 32'h02000100);
    hold(MENU_HAND, 15, 1'b0);
    chk(o_manual, 1'b0);
    hold(MENU_HAND, 25, 1'b0);
    chk({o_flash, o_manual}, 2'b11);
    chk({o_output_two_drive, o_output_one_drive}, 32'h02000100);
    bus(1'b1, OFS_CTRL, 32'h0);
    @(posedge i_clk);
    #1;
    chk(o_output_two_drive, 16'h2222);
    hold(MENU_NONE, 1, 1'b1);
    chk({o_manual, o_output_one_drive}, 17'h01111);
    bus(1'b1, OFS_BAND1, 32'h0);
    hold(MENU_HAND, 25, 1'b0);
    chk(o_manual, 1'b0);
    bus(1'b1, OFS_BAND1, 32'h00B4);
    smp(1'b0, 16'h0050);
    smp(1'b0, 16'h0030);
    rdc(OFS_PEAK, 32'h00300050);
    hold(MENU_DISP, 45, 1'b0);
    chk({o_disp_mode, o_manual, o_output_one_drive}, 18'h21111);
    rdc(OFS_PEAK, 32'hFFFF0000);
    hold(MENU_NONE, 1, 1'b1);
    chk(o_disp_mode, 1'b0);
    bus(1'b1, OFS_CTRL, 32'h20);
    @(posedge i_clk);
    i_heater_on <= 1'b1;
    smp(1'b1, 16'h0077);
    i_heater_on <= 1'b0;
    smp(1'b1, 16'h0088);
    rdc(OFS_HEATER, 32'h0077);
    bus(1'b1, OFS_FILE, 32'h1);
    bus(1'b1, OFS_FILE, 32'h2);
    rdc(OFS_FILE, 32'h1);
    bus(1'b1, OFS_SP1, 32'h0999);
    hold(MENU_FILE, 25, 1'b0);
    chk(o_reload_file, 1'b1);
    chk(reloads, 1);
    rdc(OFS_SP1, {16'h0, RST_SP});
    complete_run();
  end
endmodule : testbench
`default_nettype wire
